// *** pcd_pkg.sv ***
// Package for the controller-line command decoder: register map,
// field positions, reset values, function codes and timing.
// Assumes a single 40 MHz clock domain and a 32-bit APB register bus.
package pcd_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_STATUS     = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h0c;
  localparam logic [7:0] OFS_MAP_LO     = 8'h10;
  localparam logic [7:0] OFS_MAP_HI     = 8'h14;
  localparam logic [7:0] OFS_MAP_COMMIT = 8'h18;
  localparam logic [7:0] OFS_IO_STATE   = 8'h1c;
  localparam logic [7:0] OFS_RELAY_TGL  = 8'h20;

  // Sizes
  localparam int NUM_IN    = 8;
  localparam int NUM_RELAY = 12;
  localparam int FN_W      = 5;
  localparam int MAP_PER   = 4;   // Pins per map word
  localparam int MAP_STEP  = 8;   // Bit step of a pin field

  // Field positions
  localparam int CTRL_CONT_BIT  = 0;
  localparam int CTRL_AUTOP_BIT = 1;
  localparam int IO_RELAY_LSB   = 8;

  // Status register bit positions
  localparam int ST_CYCLE   = 0;
  localparam int ST_PEND    = 1;
  localparam int ST_STANDBY = 2;
  localparam int ST_RESULT  = 3;
  localparam int ST_CAL     = 4;
  localparam int ST_CHECK   = 5;
  localparam int ST_COARSE  = 6;
  localparam int ST_PURGE   = 7;

  // Interrupt event bit positions
  localparam int EV_BEGIN = 0;
  localparam int EV_HALT  = 1;
  localparam int EV_CAL   = 2;
  localparam int EV_CHECK = 3;
  localparam int EV_CLEAR = 4;
  localparam int EV_WAKE  = 5;
  localparam int EV_SLEEP = 6;
  localparam int EV_DONE  = 7;

  // Reset values
  localparam logic       CTRL_CONT_RST  = 1'b0;
  localparam logic       CTRL_AUTOP_RST = 1'b1;
  localparam logic       STANDBY_RST    = 1'b0;
  localparam logic [7:0] IRQ_MASK_RST   = 8'h00;
  localparam logic [1:0] WARM_DONE      = 2'h3;

  // Function codes assignable to an input pin
  typedef enum logic [4:0] {
    FN_NONE        = 5'h00,
    FN_BEGIN       = 5'h01,
    FN_HALT        = 5'h02,
    FN_BEGIN_HALT  = 5'h03,
    FN_CAL         = 5'h04,
    FN_CHECK       = 5'h05,
    FN_CLEAR       = 5'h06,
    FN_WAKE        = 5'h07,
    FN_SLEEP       = 5'h08,
    FN_COARSE_FINE = 5'h09,
    FN_PURGE       = 5'h0a,
    FN_INV_BEGIN   = 5'h0b,
    FN_INV_HALT    = 5'h0c,
    FN_HALT_BEGIN  = 5'h0d,
    FN_INVERTED_CALIBRATE_CMD     = 5'h0e,
    FN_INV_CHECK   = 5'h0f,
    FN_INVERTED_FAULT_CLEAR_CMD   = 5'h10,
    FN_INV_WAKE    = 5'h11,
    FN_INV_SLEEP   = 5'h12,
    FN_FINE_COARSE = 5'h13,
    FN_INVERTED_FLUSH_CMD   = 5'h14
  } pcd_fn_t;

  // Timing
  localparam longint CLK_HZ         = 40000000;
  localparam longint START_DELAY_MS = 3000;
  localparam longint START_DELAY_CYC = START_DELAY_MS * CLK_HZ / 1000;

endpackage

// *** pcd_decoder.sv ***
// Command decoder for discrete lines driven by an external controller,
// with an APB register slave, pin-function mapping and relay test.
// Assumes one clock; controller lines and pins are asynchronous,
// core handshake inputs are on the same clock.
//
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

module pcd_decoder #(
  parameter int unsigned START_DELAY_CYCLES =
    int'(pcd_pkg::START_DELAY_CYC)
) (
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Controller lines, asynchronous
  input  wire logic [7:0]  plc_in,
  // Measurement core handshakes
  input  wire logic        cycle_done,
  input  wire logic        cal_done,
  input  wire logic        cal_ok,
  input  wire logic        check_done,
  input  wire logic        error_pending,
  input  wire logic [11:0] relay_func,
  // Command outputs
  output logic             cycle_active,
  output logic             standby,
  output logic             result_valid,
  output logic             cycle_abort,
  output logic             cal_active,
  output logic             cal_factor_load,
  output logic             check_active,
  output logic             fault_clear,
  output logic             restart,
  output logic             coarse_mode,
  output logic             purge_active,
  output logic [11:0]      relay_out,
  output logic             irq
);

  typedef struct packed {
    logic [7:0]       sync1;
    logic [7:0]       sync2;
    logic [7:0]       prev;
    logic [7:0]       armed;
    logic [1:0]       warm;
    logic             cont;
    logic             autop;
    logic [7:0][4:0]  map_stage;
    logic [7:0][4:0]  map_act;
    logic [7:0]       irq_stat;
    logic [7:0]       irq_mask;
    logic [11:0]      toggle;
    logic [11:0]      relay;
    logic             cycle;
    logic             pend;
    logic [31:0]      delay;
    logic             standby;
    logic             result;
    logic             cal;
    logic             check;
    logic             coarse;
    logic             purge;
    logic             abort_p;
    logic             load_p;
    logic             clear_p;
    logic             restart_p;
    logic             rd_ok;
    logic [31:0]      rdata;
    logic             slverr;
  } pcd_state_t;

  pcd_state_t st_reg;
  pcd_state_t st_next;

  // Per-pin decoded events
  logic [7:0] eff;
  logic [7:0] hit_begin;
  logic [7:0] hit_halt;
  logic [7:0] hit_cal;
  logic [7:0] hit_check;
  logic [7:0] hit_clear;
  logic [7:0] hit_wake;
  logic [7:0] hit_sleep;
  logic [7:0] hit_coarse;
  logic [7:0] hit_fine;
  logic [7:0] hit_purge;

  // Decode each pin by its active function
  for (genvar g = 0; g < pcd_pkg::NUM_IN; g++) begin : g_pin
    pcd_pkg::pcd_fn_t fn;
    logic             inv;
    logic             rise;
    logic             fall;
    assign fn  = pcd_pkg::pcd_fn_t'(st_reg.map_act[g]);
    // Inverted variants see the complementary level
    assign inv = (fn == pcd_pkg::FN_INV_BEGIN) ||
                 (fn == pcd_pkg::FN_INV_HALT) ||
                 (fn == pcd_pkg::FN_INVERTED_CALIBRATE_CMD) ||
                 (fn == pcd_pkg::FN_INV_CHECK) ||
                 (fn == pcd_pkg::FN_INVERTED_FAULT_CLEAR_CMD) ||
                 (fn == pcd_pkg::FN_INV_WAKE) ||
                 (fn == pcd_pkg::FN_INV_SLEEP) ||
                 (fn == pcd_pkg::FN_INVERTED_FLUSH_CMD);
    assign eff[g] = st_reg.sync2[g] ^ inv;
    // Edges only count once the line was seen inactive
    assign rise = st_reg.armed[g] & eff[g] & ~st_reg.prev[g];
    assign fall = st_reg.armed[g] & ~eff[g] & st_reg.prev[g];
    assign hit_begin[g] =
      ((fn == pcd_pkg::FN_BEGIN || fn == pcd_pkg::FN_INV_BEGIN) & rise) |
      ((fn == pcd_pkg::FN_BEGIN_HALT) & rise) |
      ((fn == pcd_pkg::FN_HALT_BEGIN) & fall);
    assign hit_halt[g] =
      ((fn == pcd_pkg::FN_HALT || fn == pcd_pkg::FN_INV_HALT) & rise) |
      ((fn == pcd_pkg::FN_BEGIN_HALT) & fall) |
      ((fn == pcd_pkg::FN_HALT_BEGIN) & rise);
    assign hit_cal[g] = rise &
      (fn == pcd_pkg::FN_CAL || fn == pcd_pkg::FN_INVERTED_CALIBRATE_CMD);
    assign hit_check[g] = rise &
      (fn == pcd_pkg::FN_CHECK || fn == pcd_pkg::FN_INV_CHECK);
    assign hit_clear[g] = rise &
      (fn == pcd_pkg::FN_CLEAR || fn == pcd_pkg::FN_INVERTED_FAULT_CLEAR_CMD);
    assign hit_wake[g] = rise &
      (fn == pcd_pkg::FN_WAKE || fn == pcd_pkg::FN_INV_WAKE);
    assign hit_sleep[g] = rise &
      (fn == pcd_pkg::FN_SLEEP || fn == pcd_pkg::FN_INV_SLEEP);
    assign hit_coarse[g] =
      ((fn == pcd_pkg::FN_COARSE_FINE) & rise) |
      ((fn == pcd_pkg::FN_FINE_COARSE) & fall);
    assign hit_fine[g] =
      ((fn == pcd_pkg::FN_COARSE_FINE) & fall) |
      ((fn == pcd_pkg::FN_FINE_COARSE) & rise);
    // Purge follows the level, not an edge
    assign hit_purge[g] = st_reg.armed[g] & eff[g] &
      (fn == pcd_pkg::FN_PURGE || fn == pcd_pkg::FN_INVERTED_FLUSH_CMD);
  end

  // Collapsed command strobes
  logic       do_begin;
  logic       do_halt;
  logic       do_cal;
  logic       do_check;
  logic       do_clear;
  logic       do_wake;
  logic       do_sleep;
  logic       do_coarse;
  logic       do_fine;
  logic [7:0] events;

  assign do_begin  = |hit_begin;
  assign do_halt   = |hit_halt;
  assign do_cal    = |hit_cal;
  assign do_check  = |hit_check;
  assign do_clear  = |hit_clear;
  assign do_wake   = |hit_wake;
  assign do_sleep  = |hit_sleep;
  assign do_coarse = |hit_coarse;
  assign do_fine   = |hit_fine;

  // Event vector feeding the sticky status bits
  always_comb begin
    events = 8'h00;
    events[pcd_pkg::EV_BEGIN] = do_begin;
    events[pcd_pkg::EV_HALT]  = do_halt;
    events[pcd_pkg::EV_CAL]   = do_cal;
    events[pcd_pkg::EV_CHECK] = do_check;
    events[pcd_pkg::EV_CLEAR] = do_clear;
    events[pcd_pkg::EV_WAKE]  = do_wake;
    events[pcd_pkg::EV_SLEEP] = do_sleep;
    events[pcd_pkg::EV_DONE]  = cycle_done & st_reg.cycle;
  end

  // Bus phases; an access completes only on a clock-enabled edge
  logic setup_ph;
  logic wr_done;

  assign setup_ph = psel & ~st_reg.rd_ok;
  assign wr_done  = psel & penable & st_reg.rd_ok & pwrite;

  // Next-state logic for the whole block
  always_comb begin
    st_next = st_reg;
    st_next.abort_p   = 1'b0;
    st_next.load_p    = 1'b0;
    st_next.clear_p   = 1'b0;
    st_next.restart_p = 1'b0;

    // Two-stage synchroniser, then the effective level history
    st_next.sync1 = plc_in;
    st_next.sync2 = st_reg.sync1;
    st_next.prev  = eff;
    if (st_reg.warm != pcd_pkg::WARM_DONE) begin
      st_next.warm = st_reg.warm + 2'h1;
    end else begin
      // Arm a line only after it has been seen inactive
      st_next.armed = st_reg.armed | ~eff;
    end

    // Measurement cycle sequencing, halt beats begin
    if (do_halt) begin
      st_next.cycle   = 1'b0;
      st_next.pend    = 1'b0;
      st_next.result  = 1'b0;
      st_next.abort_p = st_reg.cycle | st_reg.pend;
    end else if (do_begin && !st_reg.cycle && !st_reg.pend) begin
      st_next.result = 1'b0;
      if (st_reg.standby) begin
        // Give the sensor time to settle out of standby
        st_next.standby = 1'b0;
        st_next.pend    = 1'b1;
        st_next.delay   = START_DELAY_CYCLES - 32'h1;
      end else begin
        st_next.cycle = 1'b1;
      end
    end else if (st_reg.pend) begin
      if (st_reg.delay == 32'h0) begin
        st_next.pend  = 1'b0;
        st_next.cycle = 1'b1;
      end else begin
        st_next.delay = st_reg.delay - 32'h1;
      end
    end else if (cycle_done && st_reg.cycle) begin
      st_next.cycle  = 1'b0;
      st_next.result = 1'b1;
    end

    // Calibration and its check
    if (do_cal) begin
      st_next.cal = 1'b1;
    end else if (cal_done && st_reg.cal) begin
      st_next.cal    = 1'b0;
      st_next.load_p = cal_ok;
    end
    if (do_check) begin
      st_next.check = 1'b1;
    end else if (check_done) begin
      st_next.check = 1'b0;
    end

    // Fault clear, with restart when an error was pending
    if (do_clear) begin
      st_next.clear_p   = 1'b1;
      st_next.restart_p = error_pending;
    end

    // Standby control; sleep wins if both arrive together
    if (do_sleep) begin
      st_next.standby = 1'b1;
    end else if (do_wake) begin
      st_next.standby = 1'b0;
    end

    // Coarse/fine only honoured in continuous mode
    if (st_reg.cont) begin
      if (do_coarse) begin
        st_next.coarse = 1'b1;
      end else if (do_fine) begin
        st_next.coarse = 1'b0;
      end
    end

    // Manual purge is locked out while automatic purge runs
    st_next.purge = (|hit_purge) & ~st_reg.autop;

    // Relays: core drive, flipped by test toggles
    st_next.relay = relay_func ^ st_reg.toggle;

    // Sticky interrupt bits: a new event wins over a clear
    st_next.irq_stat = st_reg.irq_stat | events;

    // Read data captured in the setup phase
    if (setup_ph) begin
      st_next.rd_ok  = 1'b1;
      st_next.slverr = 1'b0;
      st_next.rdata  = 32'h0;
      case (paddr)
        pcd_pkg::OFS_CTRL: begin
          st_next.rdata[pcd_pkg::CTRL_CONT_BIT]  = st_reg.cont;
          st_next.rdata[pcd_pkg::CTRL_AUTOP_BIT] = st_reg.autop;
        end
        pcd_pkg::OFS_STATUS: begin
          st_next.rdata[pcd_pkg::ST_CYCLE]   = st_reg.cycle;
          st_next.rdata[pcd_pkg::ST_PEND]    = st_reg.pend;
          st_next.rdata[pcd_pkg::ST_STANDBY] = st_reg.standby;
          st_next.rdata[pcd_pkg::ST_RESULT]  = st_reg.result;
          st_next.rdata[pcd_pkg::ST_CAL]     = st_reg.cal;
          st_next.rdata[pcd_pkg::ST_CHECK]   = st_reg.check;
          st_next.rdata[pcd_pkg::ST_COARSE]  = st_reg.coarse;
          st_next.rdata[pcd_pkg::ST_PURGE]   = st_reg.purge;
        end
        pcd_pkg::OFS_IRQ_STAT: st_next.rdata[7:0] = st_reg.irq_stat;
        pcd_pkg::OFS_IRQ_MASK: st_next.rdata[7:0] = st_reg.irq_mask;
        pcd_pkg::OFS_MAP_LO, pcd_pkg::OFS_MAP_HI: begin
          for (int i = 0; i < pcd_pkg::MAP_PER; i++) begin
            st_next.rdata[i*pcd_pkg::MAP_STEP +: pcd_pkg::FN_W] =
              st_reg.map_stage[i + ((paddr == pcd_pkg::OFS_MAP_HI) ?
                                    pcd_pkg::MAP_PER : 0)];
          end
        end
        pcd_pkg::OFS_MAP_COMMIT: st_next.rdata = 32'h0;
        pcd_pkg::OFS_IO_STATE: begin
          st_next.rdata[7:0] = st_reg.sync2;
          st_next.rdata[pcd_pkg::IO_RELAY_LSB +: pcd_pkg::NUM_RELAY] =
            st_reg.relay;
        end
        pcd_pkg::OFS_RELAY_TGL:
          st_next.rdata[11:0] = st_reg.toggle;
        default: st_next.slverr = 1'b1;
      endcase
    end else if (psel && penable) begin
      st_next.rd_ok = 1'b0;
    end

    // Register writes at the completing access edge
    if (wr_done) begin
      case (paddr)
        pcd_pkg::OFS_CTRL: begin
          st_next.cont  = pwdata[pcd_pkg::CTRL_CONT_BIT];
          st_next.autop = pwdata[pcd_pkg::CTRL_AUTOP_BIT];
        end
        pcd_pkg::OFS_IRQ_STAT:
          st_next.irq_stat = (st_reg.irq_stat & ~pwdata[7:0]) | events;
        pcd_pkg::OFS_IRQ_MASK: st_next.irq_mask = pwdata[7:0];
        pcd_pkg::OFS_MAP_LO, pcd_pkg::OFS_MAP_HI: begin
          for (int i = 0; i < pcd_pkg::MAP_PER; i++) begin
            st_next.map_stage[i + ((paddr == pcd_pkg::OFS_MAP_HI) ?
                                   pcd_pkg::MAP_PER : 0)] =
              pwdata[i*pcd_pkg::MAP_STEP +: pcd_pkg::FN_W];
          end
        end
        pcd_pkg::OFS_MAP_COMMIT: begin
          if (pwdata[0]) begin
            // New mapping applies only now; re-arm to avoid false edges
            st_next.map_act = st_reg.map_stage;
            st_next.armed   = 8'h00;
          end
        end
        pcd_pkg::OFS_RELAY_TGL:
          st_next.toggle = st_reg.toggle ^ pwdata[11:0];
        default: st_next.cont = st_reg.cont;
      endcase
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clock) begin
    if (srst) begin
      st_reg          <= '0;
      st_reg.cont     <= pcd_pkg::CTRL_CONT_RST;
      st_reg.autop    <= pcd_pkg::CTRL_AUTOP_RST;
      st_reg.standby  <= pcd_pkg::STANDBY_RST;
      st_reg.irq_mask <= pcd_pkg::IRQ_MASK_RST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // Zero-wait answer once the read data has been captured
  assign pready  = psel & penable & st_reg.rd_ok & ce;
  assign prdata  = st_reg.rdata;
  assign pslverr = pready & st_reg.slverr;

  // Outputs straight from the state register
  assign cycle_active    = st_reg.cycle;
  assign standby         = st_reg.standby;
  assign result_valid    = st_reg.result;
  assign cycle_abort     = st_reg.abort_p;
  assign cal_active      = st_reg.cal;
  assign cal_factor_load = st_reg.load_p;
  assign check_active    = st_reg.check;
  assign fault_clear     = st_reg.clear_p;
  assign restart         = st_reg.restart_p;
  assign coarse_mode     = st_reg.coarse;
  assign purge_active    = st_reg.purge;
  assign relay_out       = st_reg.relay;
  assign irq             = |(st_reg.irq_stat & st_reg.irq_mask);

endmodule

// *** pcd_decoder_assertions.sv ***
// Checker for the controller-line decoder, bound to its ports.
// Assumes one clock domain with srst as synchronous reset.
`timescale 1ns/1ps
module pcd_decoder_assertions (
  input wire logic       clock,
  input wire logic       srst,
  input wire logic       ce,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic [7:0] paddr,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic [7:0] plc_in,
  input wire logic       cycle_done,
  input wire logic       cal_done,
  input wire logic       cal_ok,
  input wire logic       error_pending,
  input wire logic       cycle_active,
  input wire logic       result_valid,
  input wire logic       cycle_abort,
  input wire logic       cal_active,
  input wire logic       cal_factor_load,
  input wire logic       fault_clear,
  input wire logic       restart
);
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (srst);

  // Quiet lines for a long span: a held level must not fire
  logic [7:0] lines_q;
  logic [3:0] quiet_cnt;
  always_ff @(posedge clock) begin
    lines_q <= plc_in;
    if (srst || plc_in != lines_q)
      quiet_cnt <= 4'h0;
    else if (quiet_cnt != 4'hf)
      quiet_cnt <= quiet_cnt + 4'h1;
  end

  property p_pready;
    psel && penable && ce && $past(psel && !penable && ce) |-> pready;
  endproperty
  a_pready: assert property (p_pready)
    else $error("no zero-wait answer");
  property p_slverr;
    psel && penable && pready && paddr > 8'h20 |-> pslverr;
  endproperty
  a_slverr: assert property (p_slverr)
    else $error("unmapped access not flagged");
  property p_abort;
    cycle_abort |-> !cycle_active && !result_valid;
  endproperty
  a_abort: assert property (p_abort)
    else $error("aborted cycle still shows a result");
  property p_one_pulse;
    cycle_abort || fault_clear |=> !cycle_abort && !fault_clear;
  endproperty
  a_one_pulse: assert property (p_one_pulse)
    else $error("command pulse longer than one cycle");
  property p_cal_load;
    cal_factor_load |-> $past(cal_done && cal_ok && cal_active);
  endproperty
  a_cal_load: assert property (p_cal_load)
    else $error("factor loaded without a good calibration");
  property p_restart;
    restart |-> fault_clear && $past(error_pending);
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart without clear and pending error");
  property p_quiet;
    quiet_cnt >= 4'h8 |-> !fault_clear && !cycle_abort;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("command fired on a steady level");
  property p_result;
    $rose(result_valid) |-> $past(cycle_done && cycle_active);
  endproperty
  a_result: assert property (p_result)
    else $error("result without a finished cycle");
endmodule

bind pcd_decoder pcd_decoder_assertions u_chk (
  .clock, .srst, .ce, .psel, .penable, .paddr, .pready, .pslverr,
  .plc_in, .cycle_done, .cal_done, .cal_ok, .error_pending,
  .cycle_active, .result_valid, .cycle_abort, .cal_active,
  .cal_factor_load, .fault_clear, .restart
);

// *** pcd_plc_model.sv ***
// Behavioural controller driving the discrete command lines.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module pcd_plc_model (
  input wire logic   clock,
  output logic [7:0] lines
);
  initial lines = 8'h00;
  // Change just after an edge, then hold past the sync pipeline
  task automatic drive(input int pin, input logic v);
    @(posedge clock);
    lines[pin] <= v;
    repeat (6) @(posedge clock);
    #1;
  endtask
  // Inactive level first, so a line already active never counts
  task automatic command(input int pin, input logic inv);
    drive(pin, inv);
    drive(pin, !inv);
  endtask
endmodule

// *** plc_input_command_decoder_tb.sv ***
// Self-checking bench for the controller-line command decoder.
// Assumes the start delay is shortened to DLY cycles.
`timescale 1ns/1ps
module plc_input_command_decoder_tb;
  localparam int DLY = 8;
  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic        pready, pslverr, rerr;
  logic        cycle_done = 1'b0, cal_done = 1'b0, cal_ok = 1'b0;
  logic        check_done = 1'b0, error_pending = 1'b0;
  logic [11:0] relay_func = 12'h000, relay_out;
  logic [7:0]  plc_in;
  logic        cycle_active, standby, result_valid, cycle_abort;
  logic        cal_active, cal_factor_load, check_active, fault_clear;
  logic        restart, coarse_mode, purge_active, irq;
  int          error_cnt = 0, checks_done = 0, b;
  int          aborts = 0, loads = 0, restarts = 0, clrs = 0;
  // Function code, event bit, status bit and its value afterwards
  logic [4:0]  fn_l [14] = '{5'h02, 5'h01, 5'h0c, 5'h0b, 5'h04, 5'h0e,
    5'h05, 5'h0f, 5'h06, 5'h10, 5'h08, 5'h07, 5'h12, 5'h11};
  int          ev_l [14] = '{1, 0, 1, 0, 2, 2, 3, 3, 4, 4, 6, 5, 6, 5};
  int          sb_l [14] = '{0, 0, 0, 0, 4, 4, 5, 5, 0, 0, 2, 2, 2, 2};
  logic        sv_l [14] = '{0, 1, 0, 1, 1, 1, 1, 1, 1, 1, 1, 0, 1, 0};
  logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18,
    8'h24};

  pcd_decoder #(.START_DELAY_CYCLES(DLY)) DUT (
    .clock, .srst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .plc_in, .cycle_done, .cal_done,
    .cal_ok, .check_done, .error_pending, .relay_func, .cycle_active,
    .standby, .result_valid, .cycle_abort, .cal_active,
    .cal_factor_load, .check_active, .fault_clear, .restart,
    .coarse_mode, .purge_active, .relay_out, .irq
  );
  pcd_plc_model u_plc (.clock, .lines(plc_in));

  always #12.5 clock = ~clock;
  // Pulse counters, sampled before the edge's own updates land
  always @(posedge clock) begin
    if (cycle_abort === 1'b1) aborts <= aborts + 1;
    if (cal_factor_load === 1'b1) loads <= loads + 1;
    if (restart === 1'b1) restarts <= restarts + 1;
    if (fault_clear === 1'b1) clrs <= clrs + 1;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Sample the answer at the edge itself; only the watchdog ends a wait
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic st(input int s, input logic v);
    rd(pcd_pkg::OFS_STATUS);
    chk(rdat[s], v);
  endtask
  task automatic map(input logic [31:0] lo, input logic [31:0] hi);
    wr(pcd_pkg::OFS_MAP_LO, lo);
    wr(pcd_pkg::OFS_MAP_HI, hi);
    wr(pcd_pkg::OFS_MAP_COMMIT, 32'h1);
  endtask
  // Core handshake: 0 cycle done, 1 calibration done, 2 check done
  task automatic pulse(input int s, input logic ok);
    @(posedge clock);
    {check_done, cal_done, cycle_done} <= 3'b001 << s;
    cal_ok <= ok;
    @(posedge clock);
    {check_done, cal_done, cycle_done} <= 3'b000;
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic t_reset;
    for (int i = 0; i < 7; i++) begin
      rd(ra[i]);
      chk(rdat, i == 0 ? 32'h2 : 32'h0);
      chk(rerr, i == 6);
    end
  endtask
  task automatic t_remap;
    u_plc.drive(0, 1'b1);
    wr(pcd_pkg::OFS_MAP_LO, 32'h1);
    u_plc.command(0, 1'b0);
    chk(cycle_active, 1'b0);
    wr(pcd_pkg::OFS_MAP_COMMIT, 32'h1);
    u_plc.drive(0, 1'b1);
    chk(cycle_active, 1'b0);
    u_plc.command(0, 1'b0);
    chk(cycle_active, 1'b1);
  endtask
  // Each of the seven interrupting commands and its inverted twin, with its interrupt
  task automatic t_codes;
    for (int i = 0; i < 14; i++) begin
      map({27'h0, fn_l[i]}, 32'h0);
      wr(pcd_pkg::OFS_IRQ_STAT, 32'hff);
      u_plc.command(0, fn_l[i] >= 5'h0b);
      st(sb_l[i], sv_l[i]);
      rd(pcd_pkg::OFS_IRQ_STAT);
      chk(rdat[ev_l[i]], 1'b1);
      chk(irq, 1'b0);
      wr(pcd_pkg::OFS_IRQ_MASK, 32'h1 << ev_l[i]);
      chk(irq, 1'b1);
      wr(pcd_pkg::OFS_IRQ_STAT, 32'hff);
      chk(irq, 1'b0);
      wr(pcd_pkg::OFS_IRQ_MASK, 32'h0);
    end
  endtask
  task automatic t_delay;
    map(32'h0002_0108, 32'h0);
    u_plc.command(2, 1'b0);
    u_plc.command(0, 1'b0);
    chk(standby, 1'b1);
    u_plc.command(1, 1'b0);
    chk(cycle_active, 1'b0);
    st(pcd_pkg::ST_PEND, 1'b1);
    repeat (DLY) @(posedge clock);
    #1;
    chk(cycle_active, 1'b1);
    chk(standby, 1'b0);
  endtask
  task automatic t_cycle;
    map(32'h0d03_0000, 32'h0);
    u_plc.drive(2, 1'b0);
    u_plc.drive(2, 1'b1);
    b = aborts;
    u_plc.drive(2, 1'b0);
    chk(aborts - b, 1);
    chk(cycle_active, 1'b0);
    u_plc.drive(2, 1'b1);
    chk(cycle_active, 1'b1);
    pulse(0, 1'b0);
    chk(result_valid, 1'b1);
    u_plc.drive(2, 1'b0);
    chk(result_valid, 1'b0);
    u_plc.drive(3, 1'b1);
    u_plc.drive(3, 1'b0);
    chk(cycle_active, 1'b1);
    u_plc.drive(3, 1'b1);
    chk(cycle_active, 1'b0);
  endtask
  task automatic t_cal;
    map(32'h4, 32'h0);
    b = loads;
    pulse(1, 1'b0);
    chk(loads - b, 0);
    u_plc.command(0, 1'b0);
    chk(cal_active, 1'b1);
    pulse(1, 1'b1);
    chk(loads - b, 1);
    pulse(2, 1'b0);
    chk(check_active, 1'b0);
  endtask
  task automatic t_clear;
    int c;
    map(32'h6, 32'h0);
    b = restarts;
    c = clrs;
    @(posedge clock);
    error_pending <= 1'b1;
    u_plc.command(0, 1'b0);
    chk(restarts - b, 1);
    @(posedge clock);
    error_pending <= 1'b0;
    u_plc.command(0, 1'b0);
    chk(restarts - b, 1);
    chk(clrs - c, 2);
  endtask
  task automatic t_mode;
    map(32'h0, 32'h1309);
    b = clrs;
    u_plc.command(4, 1'b0);
    chk(coarse_mode, 1'b0);
    wr(pcd_pkg::OFS_CTRL, 32'h3);
    u_plc.command(4, 1'b0);
    chk(coarse_mode, 1'b1);
    u_plc.drive(4, 1'b0);
    chk(coarse_mode, 1'b0);
    u_plc.drive(5, 1'b1);
    u_plc.drive(5, 1'b0);
    chk(coarse_mode, 1'b1);
    u_plc.drive(5, 1'b1);
    chk(coarse_mode, 1'b0);
    chk(clrs - b, 0);
  endtask
  task automatic t_purge;
    map(32'h0, 32'h140a_0000);
    u_plc.drive(6, 1'b1);
    chk(purge_active, 1'b0);
    u_plc.drive(6, 1'b0);
    wr(pcd_pkg::OFS_CTRL, 32'h1);
    u_plc.drive(6, 1'b1);
    chk(purge_active, 1'b1);
    u_plc.drive(6, 1'b0);
    chk(purge_active, 1'b0);
    u_plc.drive(7, 1'b1);
    u_plc.drive(7, 1'b0);
    chk(purge_active, 1'b1);
  endtask
  task automatic t_relay;
    @(posedge clock);
    relay_func <= 12'h5a5;
    wr(pcd_pkg::OFS_RELAY_TGL, 32'hf);
    rd(pcd_pkg::OFS_IO_STATE);
    chk(rdat, {12'h000, 12'h5aa, plc_in});
    rd(pcd_pkg::OFS_RELAY_TGL);
    chk(rdat, 32'hf);
    wr(pcd_pkg::OFS_RELAY_TGL, 32'h1);
    // Relay output is registered one cycle after the toggle mask
    @(posedge clock);
    #1;
    chk(relay_out, 12'h5ab);
    // Clock enable low must freeze the relay register
    @(posedge clock);
    ce <= 1'b0;
    relay_func <= 12'h000;
    repeat (3) @(posedge clock);
    #1;
    chk(relay_out, 12'h5ab);
    @(posedge clock);
    ce <= 1'b1;
  endtask

  initial begin
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    repeat (4) @(posedge clock);
    t_reset;
    t_remap;
    t_codes;
    t_delay;
    t_cycle;
    t_cal;
    t_clear;
    t_mode;
    t_purge;
    t_relay;
    close_out;
  end
  // Hang guard, far beyond the roughly one thousand cycles the run needs
  initial begin
    #(25 * 30000);
    error_cnt++;
    close_out;
  end
endmodule
